// ===== bench/wol_detector_props.sv
// Port checker for the wake detector: read answers and what may move the wake outputs.
// Assumes it is bound to wol_detector and sees its ports only.
module wol_detector_props #(
	parameter int PAT_LEN = 64
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic rx_dv_in,
	input wire logic [wol_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [wol_pkg::REG_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [wol_pkg::REG_W-1:0] reg_rdata_out,
	input wire logic irq_out,
	input wire logic wake_gpio_out
);
	import wol_pkg::*;
	logic [6:0] cfg_r;
	logic [6:0] cfg_nxt;
	logic [1:0] mask_r;
	logic [1:0] mask_nxt;
	always_comb begin
		cfg_nxt = cfg_r;
		mask_nxt = mask_r;
		if (reg_wr_in && reg_addr_in == OFS_CFG)
			cfg_nxt = reg_wdata_in[6:0];
		if (reg_wr_in && reg_addr_in == OFS_IMASK)
			mask_nxt = reg_wdata_in[1:0];
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_r <= 7'h00;
			mask_r <= IMASK_RST;
		end else begin
			cfg_r <= cfg_nxt;
			mask_r <= mask_nxt;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Frame end and software writes are the only causes allowed to raise a wake output
	sequence s_quiet;
		!reg_wr_in && (rx_dv_in || !$past(rx_dv_in));
	endsequence
	sequence s_wake_clr;
		reg_wr_in && reg_addr_in == OFS_ISTS && reg_wdata_in[IRQ_WAKE]
			&& (rx_dv_in || !$past(rx_dv_in));
	endsequence
	rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == '0)
		else $error("read data not zero outside answer cycle");
	cfg_read_a: assert property (reg_rd_in && reg_addr_in == OFS_CFG |=> reg_rdata_out[6:0] == cfg_r)
		else $error("config readback differs from written value");
	irq_gate_a: assert property (irq_out |-> cfg_r[CFG_IRQ_EN] && mask_r != 2'h0)
		else $error("irq high while disabled or masked");
	gpio_gate_a: assert property (wake_gpio_out |-> cfg_r[CFG_GPIO_EN])
		else $error("wake pin high while disabled");
	irq_cause_a: assert property (s_quiet |=> !$rose(irq_out))
		else $error("irq rose without frame end or write");
	gpio_cause_a: assert property (s_quiet |=> !$rose(wake_gpio_out))
		else $error("wake pin rose without frame end or write");
	wake_hold_a: assert property (wake_gpio_out && !reg_wr_in |=> wake_gpio_out)
		else $error("wake pin dropped without a write");
	wake_clr_a: assert property (s_wake_clr |=> !wake_gpio_out)
		else $error("wake pin stayed after clear");
endmodule

bind wol_detector wol_detector_props #(.PAT_LEN(PAT_LEN)) props_u (
	.clk_in(clk_in), .rstn_in(rstn_in), .rx_dv_in(rx_dv_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
	.wake_gpio_out(wake_gpio_out)
);

// ===== bench/wol_detector_tb_top.sv
// Testbench for the wake detector: register access, wake frames and wake outputs.
// Assumes the link model supplies frames and the detector answers reads one cycle later.
module wol_detector_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import wol_pkg::*;
	logic clk_in, rstn_in, rx_dv, rx_er, rx_valid, nib_mode, reg_wr, reg_rd, irq, gpio, mask_v;
	logic [7:0] rx_data;
	logic [15:0] reg_addr, reg_wdata, reg_rdata;
	logic [7:0] mac[6] = '{8'h02, 8'h1A, 8'h2B, 8'h3C, 8'h4D, 8'h5E};
	logic [7:0] pwd[6] = '{8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E, 8'h9F};
	int num_errors = 0;
	int total_checks = 0;
	int test_no = 0;
	wol_link_model mdl_u (.clk_in(clk_in), .rx_dv_out(rx_dv), .rx_er_out(rx_er),
		.rx_valid_out(rx_valid), .rx_data_out(rx_data));
	wol_detector #(.PAT_LEN(64)) dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .rx_dv_in(rx_dv),
		.rx_er_in(rx_er), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
		.rx_nibble_mode_in(nib_mode), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .irq_out(irq),
		.wake_gpio_out(gpio));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp_pin(input string n, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// f: 0 broadcast, 1 broken sync, 2 password, 3 nibble, 4 bad FCS, 5 pattern, 6 rx error
	task automatic run(input logic [15:0] c, input int ns, input int reps, input logic [6:0] f,
		input logic [1:0] e);
		logic [15:0] d;
		wr(OFS_CFG, c);
		nib_mode <= f[3];
		if (f[5])
			for (int i = 0; i < 64; i++) mdl_u.q.push_back(i < 6 ? mac[i] : 8'(i));
		else begin
			for (int i = 0; i < 12; i++) mdl_u.q.push_back(i > 5 ? 8'h0A : f[0] ? 8'hFF : mac[i]);
			if (f[1])
				for (int i = 0; i < 8; i++) mdl_u.q.push_back(i < 6 ? 8'hFF : mac[i - 6]);
			repeat (ns) mdl_u.q.push_back(8'hFF);
			for (int i = 0; i < reps * 6; i++) mdl_u.q.push_back(mac[i % 6]);
			if (f[2])
				for (int i = 0; i < 6; i++) mdl_u.q.push_back(pwd[i]);
		end
		mdl_u.send(f[3], f[4], f[6]);
		repeat (3) @(posedge clk_in);
		rd(OFS_ISTS, d);
		cmp("wake status", {14'h0000, e}, d);
		cmp_pin("irq", c[CFG_IRQ_EN] & e[IRQ_WAKE] & mask_v, irq);
		cmp_pin("gpio", c[CFG_GPIO_EN] & e[IRQ_WAKE], gpio);
		rd(OFS_STS, d);
		// Verdict source and CRC flag only move for candidate frames
		if (e != 2'h0)
			cmp("verdict", {13'h0000, e[IRQ_CRC], f[5], !f[5]},
				{13'h0000, d[STS_CRC_BAD], d[STS_PAT], d[STS_SEQ]});
		wr(OFS_ISTS, 16'h0003);
		test_no++;
		$display("test %0d done", test_no);
	endtask
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	initial begin
		repeat (50000) @(posedge clk_in);
		num_errors++;
		wrap_up();
	end
	initial begin
		logic [15:0] d;
		rstn_in = 1'b0;
		nib_mode = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		mask_v = 1'b1;
		repeat (12) @(posedge clk_in);
		rstn_in <= 1'b1;
		rd(OFS_STS, d);
		cmp("status reset", 16'h0000, d);
		wr(OFS_CFG, 16'h007F);
		rd(OFS_CFG, d);
		cmp("config", 16'h007F, d);
		wr(OFS_STS, 16'h00FF);
		rd(OFS_STS, d);
		cmp("status write", 16'h0000, d);
		rd(16'h0200, d);
		cmp("unmapped", 16'h0000, d);
		$display("test register map done");
		wr(OFS_MAC_HI, 16'h021A);
		wr(OFS_MAC_MID, 16'h2B3C);
		wr(OFS_MAC_LO, 16'h4D5E);
		wr(OFS_PW_HI, 16'h9A9B);
		wr(OFS_PW_MID, 16'h9C9D);
		wr(OFS_PW_LO, 16'h9E9F);
		wr(OFS_IMASK, 16'h0001);
		for (int i = 0; i < 64; i++) begin
			wr(OFS_PAT, {2'b00, 6'(i), i < 6 ? mac[i] : 8'(i)});
		end
		run(16'h0065, 6, 16, 7'h00, 2'h1);
		run(16'h0065, 6, 15, 7'h00, 2'h0);
		run(16'h0065, 5, 16, 7'h00, 2'h0);
		run(16'h0065, 6, 16, 7'h10, 2'h2);
		run(16'h0065, 6, 16, 7'h40, 2'h2);
		run(16'h0065, 6, 16, 7'h08, 2'h1);
		run(16'h0065, 6, 16, 7'h01, 2'h0);
		run(16'h0067, 6, 16, 7'h01, 2'h1);
		run(16'h0063, 6, 16, 7'h00, 2'h0);
		run(16'h0065, 6, 16, 7'h02, 2'h1);
		run(16'h006D, 6, 16, 7'h00, 2'h0);
		run(16'h006D, 6, 16, 7'h04, 2'h1);
		run(16'h0075, 0, 0, 7'h20, 2'h1);
		run(16'h0064, 6, 16, 7'h00, 2'h0);
		run(16'h0005, 6, 16, 7'h00, 2'h1);
		mask_v = 1'b0;
		wr(OFS_IMASK, 16'h0000);
		run(16'h0065, 6, 16, 7'h00, 2'h1);
		wrap_up();
	end
endmodule

// ===== bench/wol_link_model.sv
// Line-side sender model: plays queued frame bytes into the receive port, FCS appended.
// Assumes the testbench fills q and sets the nibble mode of the detector to match.
module wol_link_model (
	input wire logic clk_in,
	output logic rx_dv_out,
	output logic rx_er_out,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import wol_pkg::*;
	logic [7:0] q[$];
	initial begin
		rx_dv_out = 1'b0;
		rx_er_out = 1'b0;
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
	end
	task automatic send(input bit nib, input bit bad, input bit er);
		logic [31:0] c;
		c = CRC_INIT;
		foreach (q[i]) begin
			c = c ^ {24'h00_0000, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		c = ~c ^ 32'(bad);
		for (int i = 0; i < 4; i++) q.push_back(c[8*i +: 8]);
		// Whole bytes only, low nibble first in nibble mode
		foreach (q[i]) for (int h = 0; h <= int'(nib); h++) begin
			@(posedge clk_in);
			rx_dv_out <= 1'b1;
			rx_valid_out <= 1'b1;
			rx_data_out <= nib ? {4'h0, q[i][4*h +: 4]} : q[i];
			// A receive error on the second byte spoils an otherwise clean frame
			rx_er_out <= er && i == 1;
		end
		@(posedge clk_in);
		rx_dv_out <= 1'b0;
		rx_valid_out <= 1'b0;
		rx_er_out <= 1'b0;
		// Released data line must not keep the last value
		rx_data_out <= ~rx_data_out;
		q.delete();
	endtask
endmodule

// ===== hdl/wol_detector.sv
// Wake-on-LAN frame detector: sequence matcher, pattern matcher, CRC check, registers.
// Assumes receive signals synchronous to clk_in, one byte or nibble per valid strobe.
module wol_detector #(
	parameter int PAT_LEN = 64
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic rx_dv_in,
	input wire logic rx_er_in,
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_nibble_mode_in,
	input wire logic [wol_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [wol_pkg::REG_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [wol_pkg::REG_W-1:0] reg_rdata_out,
	output logic irq_out,
	output logic wake_gpio_out
);
	import wol_pkg::*;

	localparam int PIW = $clog2(PAT_LEN);

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {24'h00_0000, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// First byte on the wire is the most significant byte of the word
	function automatic logic [7:0] sel_byte(input logic [47:0] w, input logic [2:0] idx);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < MAC_BYTES; i++) begin
			if (idx == 3'(i)) begin
				r = w[47-8*i -: 8];
			end
		end
		return r;
	endfunction

	// A byte that breaks a run may itself open the next sync run
	function automatic logic [2:0] sync_restart(input logic [7:0] b);
		return (b == SYNC_BYTE) ? 3'h1 : 3'h0;
	endfunction

	// Register state
	logic [15:0] cfg_r, cfg_nxt;
	logic [47:0] mac_r, mac_nxt;
	logic [47:0] pw_r, pw_nxt;
	logic [1:0] imask_r, imask_nxt;
	logic [1:0] ists_r, ists_nxt;
	logic [3:0] stat_r, stat_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	logic gpio_r, gpio_nxt;
	logic [7:0] pat_mem [PAT_LEN];

	// Frame state
	logic dv_q_r, dv_q_nxt;
	logic nib_have_r, nib_have_nxt;
	logic [3:0] nib_lo_r, nib_lo_nxt;
	wol_phase_t phase_r, phase_nxt;
	logic [2:0] sync_r, sync_nxt;
	logic [3:0] rep_r, rep_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic [PIW:0] cnt_r, cnt_nxt;
	logic uc_r, uc_nxt;
	logic bc_r, bc_nxt;
	logic pat_ok_r, pat_ok_nxt;
	logic err_r, err_nxt;
	logic [31:0] crc_r, crc_nxt;

	logic byte_stb;
	logic [7:0] byte_val;
	logic frame_end;
	logic cand;
	logic seq_hit;
	logic pat_hit;
	logic crc_good;
	logic ev_wake;
	logic ev_crc;

	// Nibble-wide speeds are folded into bytes here so the matcher never sees the rate
	always_comb begin
		byte_stb = 1'b0;
		byte_val = rx_data_in;
		nib_have_nxt = nib_have_r;
		nib_lo_nxt = nib_lo_r;
		if (!rx_dv_in) begin
			nib_have_nxt = 1'b0;
		end else if (rx_valid_in) begin
			if (rx_nibble_mode_in) begin
				if (nib_have_r) begin
					byte_stb = 1'b1;
					byte_val = {rx_data_in[3:0], nib_lo_r};
					nib_have_nxt = 1'b0;
				end else begin
					nib_lo_nxt = rx_data_in[3:0];
					nib_have_nxt = 1'b1;
				end
			end else begin
				byte_stb = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			nib_have_r <= 1'b0;
			nib_lo_r <= 4'h0;
		end else begin
			nib_have_r <= nib_have_nxt;
			nib_lo_r <= nib_lo_nxt;
		end
	end

	always_comb begin
		dv_q_nxt = rx_dv_in;
		phase_nxt = phase_r;
		sync_nxt = sync_r;
		rep_nxt = rep_r;
		idx_nxt = idx_r;
		cnt_nxt = cnt_r;
		uc_nxt = uc_r;
		bc_nxt = bc_r;
		pat_ok_nxt = pat_ok_r;
		err_nxt = err_r;
		crc_nxt = crc_r;
		if (rx_dv_in && !dv_q_r) begin
			phase_nxt = PH_HUNT;
			sync_nxt = 3'h0;
			rep_nxt = 4'h0;
			idx_nxt = 3'h0;
			cnt_nxt = '0;
			uc_nxt = 1'b1;
			bc_nxt = 1'b1;
			pat_ok_nxt = 1'b1;
			err_nxt = 1'b0;
			crc_nxt = CRC_INIT;
		end
		if (rx_dv_in && rx_er_in) begin
			err_nxt = 1'b1;
		end
		// Whole bytes only: a sequence off byte boundaries never matches
		if (byte_stb) begin
			crc_nxt = crc_byte(crc_nxt, byte_val);
			if (cnt_nxt < (PIW+1)'(MAC_BYTES)) begin
				uc_nxt = uc_nxt && (byte_val == sel_byte(mac_r, cnt_nxt[2:0]));
				bc_nxt = bc_nxt && (byte_val == SYNC_BYTE);
			end
			if (cnt_nxt < (PIW+1)'(PAT_LEN)) begin
				pat_ok_nxt = pat_ok_nxt && (byte_val == pat_mem[cnt_nxt[PIW-1:0]]);
				cnt_nxt = cnt_nxt + 1'b1;
			end
			// Matcher runs over every byte, so the sequence can start anywhere
			case (phase_nxt)
				PH_HUNT: begin
					if (sync_nxt == SYNC_LEN && byte_val == sel_byte(mac_r, 3'h0)) begin
						phase_nxt = PH_ADDR;
						idx_nxt = 3'h1;
						rep_nxt = 4'h0;
					end else if (byte_val == SYNC_BYTE) begin
						sync_nxt = (sync_nxt == SYNC_LEN) ? sync_nxt : sync_nxt + 3'h1;
					end else begin
						sync_nxt = 3'h0;
					end
				end
				PH_ADDR: begin
					if (byte_val == sel_byte(mac_r, idx_nxt)) begin
						if (idx_nxt == LAST_BYTE) begin
							idx_nxt = 3'h0;
							if (rep_nxt == LAST_REP) begin
								phase_nxt = cfg_r[CFG_PW_EN] ? PH_PASS : PH_FOUND;
							end else begin
								rep_nxt = rep_nxt + 4'h1;
							end
						end else begin
							idx_nxt = idx_nxt + 3'h1;
						end
					end else begin
						phase_nxt = PH_HUNT;
						sync_nxt = sync_restart(byte_val);
						idx_nxt = 3'h0;
						rep_nxt = 4'h0;
					end
				end
				PH_PASS: begin
					if (byte_val == sel_byte(pw_r, idx_nxt)) begin
						if (idx_nxt == LAST_BYTE) begin
							phase_nxt = PH_FOUND;
						end else begin
							idx_nxt = idx_nxt + 3'h1;
						end
					end else begin
						phase_nxt = PH_HUNT;
						sync_nxt = sync_restart(byte_val);
						idx_nxt = 3'h0;
						rep_nxt = 4'h0;
					end
				end
				PH_FOUND: begin
					phase_nxt = PH_FOUND;
				end
				default: begin
					phase_nxt = PH_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dv_q_r <= 1'b0;
			phase_r <= PH_HUNT;
			sync_r <= 3'h0;
			rep_r <= 4'h0;
			idx_r <= 3'h0;
			cnt_r <= '0;
			uc_r <= 1'b0;
			bc_r <= 1'b0;
			pat_ok_r <= 1'b0;
			err_r <= 1'b0;
			crc_r <= CRC_INIT;
		end else begin
			dv_q_r <= dv_q_nxt;
			phase_r <= phase_nxt;
			sync_r <= sync_nxt;
			rep_r <= rep_nxt;
			idx_r <= idx_nxt;
			cnt_r <= cnt_nxt;
			uc_r <= uc_nxt;
			bc_r <= bc_nxt;
			pat_ok_r <= pat_ok_nxt;
			err_r <= err_nxt;
			crc_r <= crc_nxt;
		end
	end

	// Verdict at the end of the frame, once the FCS has gone through the checker
	always_comb begin
		frame_end = dv_q_r && !rx_dv_in;
		cand = cfg_r[CFG_WAKE_EN] &&
			((uc_r && cfg_r[CFG_UCAST_EN]) || (bc_r && cfg_r[CFG_BCAST_EN]));
		seq_hit = (phase_r == PH_FOUND);
		// A frame shorter than the pattern cannot match it
		pat_hit = cfg_r[CFG_PAT_EN] && pat_ok_r && (cnt_r == (PIW+1)'(PAT_LEN));
		crc_good = (crc_r == CRC_RESIDUE) && !err_r;
		ev_wake = frame_end && cand && (seq_hit || pat_hit) && crc_good;
		ev_crc = frame_end && cand && (seq_hit || pat_hit) && !crc_good;
	end

	always_comb begin
		cfg_nxt = cfg_r;
		mac_nxt = mac_r;
		pw_nxt = pw_r;
		imask_nxt = imask_r;
		ists_nxt = ists_r;
		stat_nxt = stat_r;
		rdata_nxt = 16'h0000;
		if (reg_wr_in) begin
			case (reg_addr_in)
				OFS_CFG: cfg_nxt = reg_wdata_in;
				OFS_MAC_HI: mac_nxt[47:32] = reg_wdata_in;
				OFS_MAC_MID: mac_nxt[31:16] = reg_wdata_in;
				OFS_MAC_LO: mac_nxt[15:0] = reg_wdata_in;
				OFS_PW_HI: pw_nxt[47:32] = reg_wdata_in;
				OFS_PW_MID: pw_nxt[31:16] = reg_wdata_in;
				OFS_PW_LO: pw_nxt[15:0] = reg_wdata_in;
				OFS_IMASK: imask_nxt = reg_wdata_in[1:0];
				OFS_ISTS: ists_nxt = ists_r & ~reg_wdata_in[1:0];
				default: begin
				end
			endcase
		end
		// New events win over a clear in the same cycle
		if (ev_wake) begin
			ists_nxt[IRQ_WAKE] = 1'b1;
		end
		if (ev_crc) begin
			ists_nxt[IRQ_CRC] = 1'b1;
		end
		if (ev_wake || ev_crc) begin
			stat_nxt[STS_SEQ] = seq_hit;
			stat_nxt[STS_PAT] = pat_hit;
			stat_nxt[STS_CRC_BAD] = ev_crc;
		end
		stat_nxt[STS_FOUND] = (phase_nxt == PH_FOUND);
		if (reg_rd_in) begin
			case (reg_addr_in)
				OFS_CFG: rdata_nxt = cfg_r;
				OFS_STS: rdata_nxt = {12'h000, stat_r};
				OFS_MAC_HI: rdata_nxt = mac_r[47:32];
				OFS_MAC_MID: rdata_nxt = mac_r[31:16];
				OFS_MAC_LO: rdata_nxt = mac_r[15:0];
				OFS_PW_HI: rdata_nxt = pw_r[47:32];
				OFS_PW_MID: rdata_nxt = pw_r[31:16];
				OFS_PW_LO: rdata_nxt = pw_r[15:0];
				OFS_IMASK: rdata_nxt = {14'h0000, imask_r};
				OFS_ISTS: rdata_nxt = {14'h0000, ists_r};
				default: rdata_nxt = 16'h0000;
			endcase
		end
		irq_nxt = cfg_nxt[CFG_IRQ_EN] && |(ists_nxt & imask_nxt);
		gpio_nxt = cfg_nxt[CFG_GPIO_EN] && ists_nxt[IRQ_WAKE];
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_r <= CFG_RST;
			mac_r <= 48'h0000_0000_0000;
			pw_r <= 48'h0000_0000_0000;
			imask_r <= IMASK_RST;
			ists_r <= 2'h0;
			stat_r <= 4'h0;
			rdata_r <= 16'h0000;
			irq_r <= 1'b0;
			gpio_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			mac_r <= mac_nxt;
			pw_r <= pw_nxt;
			imask_r <= imask_nxt;
			ists_r <= ists_nxt;
			stat_r <= stat_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
			gpio_r <= gpio_nxt;
		end
	end

	// Pattern storage has no reset; software loads it before enabling the match
	always_ff @(posedge clk_in) begin
		if (reg_wr_in && reg_addr_in == OFS_PAT) begin
			pat_mem[reg_wdata_in[PAT_IDX_LSB +: PIW]] <= reg_wdata_in[PAT_DATA_LSB +: 8];
		end
	end

	assign reg_rdata_out = rdata_r;
	assign irq_out = irq_r;
	assign wake_gpio_out = gpio_r;
endmodule

// ===== shared/wol_pkg.sv
// Constants, register map and state codes of the wake-on-LAN frame detector.
// Assumes a byte- or nibble-wide receive stream and a simple strobed register port.
// Behaviour
// - Scan frames addressed here while enabled
// - Accept own address or broadcast destination
// - Require sixteen back-to-back station address copies
// - Copies must follow six 0xFF sync bytes
// - Password must follow copies when enabled
// - Sequence may start at any byte
// - Bad CRC suppresses the wake indication
// - Valid wake frame raises interrupt when enabled
// - Optionally drive general-purpose wake pin
// - Same detection at all link speeds
// - One 64-byte pattern match also wakes
// - Separate broadcast and unicast wake enables
// - Configuration register at 0x0134
// - Status register at 0x0135
package wol_pkg;
	localparam int REG_W = 16;
	localparam int ADDR_W = 16;

	localparam logic [15:0] OFS_CFG = 16'h0134;
	localparam logic [15:0] OFS_STS = 16'h0135;
	localparam logic [15:0] OFS_MAC_HI = 16'h0136;
	localparam logic [15:0] OFS_MAC_MID = 16'h0137;
	localparam logic [15:0] OFS_MAC_LO = 16'h0138;
	localparam logic [15:0] OFS_PW_HI = 16'h0139;
	localparam logic [15:0] OFS_PW_MID = 16'h013A;
	localparam logic [15:0] OFS_PW_LO = 16'h013B;
	localparam logic [15:0] OFS_PAT = 16'h013C;
	localparam logic [15:0] OFS_IMASK = 16'h013D;
	localparam logic [15:0] OFS_ISTS = 16'h013E;

	// Configuration fields
	localparam int CFG_WAKE_EN = 0;
	localparam int CFG_BCAST_EN = 1;
	localparam int CFG_UCAST_EN = 2;
	localparam int CFG_PW_EN = 3;
	localparam int CFG_PAT_EN = 4;
	localparam int CFG_IRQ_EN = 5;
	localparam int CFG_GPIO_EN = 6;
	localparam logic [15:0] CFG_RST = 16'h0000;

	// Status fields
	localparam int STS_SEQ = 0;
	localparam int STS_PAT = 1;
	localparam int STS_CRC_BAD = 2;
	localparam int STS_FOUND = 3;

	// Interrupt status and mask fields
	localparam int IRQ_WAKE = 0;
	localparam int IRQ_CRC = 1;
	localparam logic [1:0] IMASK_RST = 2'h0;

	// Pattern write word: byte index and byte value
	localparam int PAT_IDX_LSB = 8;
	localparam int PAT_DATA_LSB = 0;

	localparam int MAC_BYTES = 6;
	localparam logic [2:0] LAST_BYTE = 3'h5;
	localparam logic [2:0] SYNC_LEN = 3'h6;
	localparam logic [3:0] LAST_REP = 4'hF;
	localparam logic [7:0] SYNC_BYTE = 8'hFF;
	localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
	localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
	localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;

	typedef enum logic [1:0] {
		PH_HUNT = 2'b00,
		PH_ADDR = 2'b01,
		PH_PASS = 2'b10,
		PH_FOUND = 2'b11
	} wol_phase_t;
endpackage
